// File: hdl/commutation_pkg.sv
package commutation_pkg;

  // Per-phase output state
  typedef enum logic [1:0] {
    PH_FLOAT = 2'h0,
    PH_LOW   = 2'h1,
    PH_HIGH  = 2'h2
  } phase_state_t;

  // Sequencer step, Gray coded along the stepping order
  typedef enum logic [2:0] {
    STEP_0 = 3'h0,
    STEP_1 = 3'h1,
    STEP_2 = 3'h3,
    STEP_3 = 3'h2,
    STEP_4 = 3'h6,
    STEP_5 = 3'h4
  } step_t;

  // Drive request for the three phases
  typedef struct packed {
    phase_state_t a;
    phase_state_t b;
    phase_state_t c;
  } phase_set_t;

  // Per-transistor signals: bit 0 upper (high side), bit 1 lower
  typedef struct packed {
    logic [1:0] a;
    logic [1:0] b;
    logic [1:0] c;
  } xtor_set_t;

  localparam int unsigned SYNC_STAGES = 2;

endpackage

// File: hdl/pin_sync.sv
module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  import commutation_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t state_q;
  sync_state_t state_d;

  always_comb begin
    state_d        = state_q;
    state_d.meta   = async_in;
    state_d.stable = state_q.meta;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign sync_out = state_q.stable;

endmodule

// File: hdl/three_phase_commutation_sequencer.sv
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
module three_phase_commutation_sequencer (
  input  wire logic                         clk,
  input  wire logic                         sys_rst,
  input  wire logic                         rotation_sel,
  input  wire logic                         seq_reset,
  input  wire logic                         brake,
  input  wire logic                         test_disable,
  input  wire logic                         commutate,
  input  wire commutation_pkg::xtor_set_t   overtemp,
  output commutation_pkg::phase_set_t       phase_state,
  output commutation_pkg::xtor_set_t        xtor_on,
  output logic                              phase_a_drive,
  output logic                              phase_b_drive,
  output logic                              phase_c_drive,
  output logic                              phase_a_oe,
  output logic                              phase_b_oe,
  output logic                              phase_c_oe,
  output commutation_pkg::step_t            step
);
  import commutation_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; commutate comes from on-chip timing on clk

  logic [9:0] pins_sync;
  logic       rot_s;
  logic       rst_s;
  logic       brk_s;
  logic       tst_s;
  xtor_set_t  ot_s;

  pin_sync #(
    .WIDTH (10)
  ) u_pin_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in ({rotation_sel, seq_reset, brake, test_disable, overtemp}),
    .sync_out (pins_sync)
  );

  assign {rot_s, rst_s, brk_s, tst_s, ot_s} = pins_sync;

  //////////////////////////////////////////////////////////////////////////////
  // Step to pattern tables

  function automatic phase_set_t fwd_pattern(input step_t s);
    unique case (s)
      STEP_0:  fwd_pattern = '{PH_FLOAT, PH_LOW,   PH_HIGH};
      STEP_1:  fwd_pattern = '{PH_HIGH,  PH_LOW,   PH_FLOAT};
      STEP_2:  fwd_pattern = '{PH_HIGH,  PH_FLOAT, PH_LOW};
      STEP_3:  fwd_pattern = '{PH_FLOAT, PH_HIGH,  PH_LOW};
      STEP_4:  fwd_pattern = '{PH_LOW,   PH_HIGH,  PH_FLOAT};
      STEP_5:  fwd_pattern = '{PH_LOW,   PH_FLOAT, PH_HIGH};
      default: fwd_pattern = '{PH_FLOAT, PH_FLOAT, PH_FLOAT};
    endcase
  endfunction

  function automatic phase_set_t rev_pattern(input step_t s);
    unique case (s)
      STEP_0:  rev_pattern = '{PH_HIGH,  PH_LOW,   PH_FLOAT};
      STEP_1:  rev_pattern = '{PH_FLOAT, PH_LOW,   PH_HIGH};
      STEP_2:  rev_pattern = '{PH_LOW,   PH_FLOAT, PH_HIGH};
      STEP_3:  rev_pattern = '{PH_LOW,   PH_HIGH,  PH_FLOAT};
      STEP_4:  rev_pattern = '{PH_FLOAT, PH_HIGH,  PH_LOW};
      STEP_5:  rev_pattern = '{PH_HIGH,  PH_FLOAT, PH_LOW};
      default: rev_pattern = '{PH_FLOAT, PH_FLOAT, PH_FLOAT};
    endcase
  endfunction

  function automatic step_t next_step(input step_t s);
    unique case (s)
      STEP_0:  next_step = STEP_1;
      STEP_1:  next_step = STEP_2;
      STEP_2:  next_step = STEP_3;
      STEP_3:  next_step = STEP_4;
      STEP_4:  next_step = STEP_5;
      STEP_5:  next_step = STEP_0;
      default: next_step = STEP_0;
    endcase
  endfunction

  function automatic logic [1:0] gates(input phase_state_t p,
                                       input logic [1:0]   hot);
    logic [1:0] g;
    g = {p == PH_LOW, p == PH_HIGH};
    // Sensor only meaningful while conducting, so it gates its own device
    gates = g & ~hot;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    step_t      step;
    phase_set_t phases;
    xtor_set_t  xtor;
  } seq_state_t;

  seq_state_t state_q;
  seq_state_t state_d;
  phase_set_t pat;

  always_comb begin
    state_d = state_q;
    pat     = rot_s ? fwd_pattern(state_q.step) : rev_pattern(state_q.step);
    if (brk_s) begin
      state_d.phases = '{PH_LOW, PH_LOW, PH_LOW};
    end else if (tst_s) begin
      state_d.phases = '{PH_FLOAT, PH_FLOAT, PH_FLOAT};
    end else if (rst_s) begin
      state_d.step   = STEP_0;
      state_d.phases = rot_s ? fwd_pattern(STEP_0)
                             : rev_pattern(STEP_0);
    end else begin
      // Pattern follows the held step; an event moves it on next cycle
      state_d.phases = pat;
      if (commutate) begin
        state_d.step = next_step(state_q.step);
      end
    end
    state_d.xtor.a = gates(state_d.phases.a, ot_s.a);
    state_d.xtor.b = gates(state_d.phases.b, ot_s.b);
    state_d.xtor.c = gates(state_d.phases.c, ot_s.c);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= '{STEP_0, '{PH_FLOAT, PH_FLOAT, PH_FLOAT}, '0};
    end else begin
      state_q <= state_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs; a disabled transistor leaves the phase floating

  assign phase_state   = state_q.phases;
  assign xtor_on       = state_q.xtor;
  assign step          = state_q.step;
  assign phase_a_drive = state_q.xtor.a[0];
  assign phase_b_drive = state_q.xtor.b[0];
  assign phase_c_drive = state_q.xtor.c[0];
  assign phase_a_oe    = |state_q.xtor.a;
  assign phase_b_oe    = |state_q.xtor.b;
  assign phase_c_oe    = |state_q.xtor.c;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  a_brake_all_low: assert property (@(posedge clk) disable iff (sys_rst)
    brk_s |=> (phase_state == phase_set_t'{PH_LOW, PH_LOW, PH_LOW}))
    else $error("brake did not drive all phases low");

  a_test_all_float: assert property (@(posedge clk) disable iff (sys_rst)
    (!brk_s && tst_s)
      |=> (phase_state == phase_set_t'{PH_FLOAT, PH_FLOAT, PH_FLOAT}))
    else $error("test did not float all phases");

  a_reset_fwd_state: assert property (@(posedge clk)
    disable iff (sys_rst)
    (!brk_s && !tst_s && rst_s && rot_s)
      |=> (phase_state == phase_set_t'{PH_FLOAT, PH_LOW, PH_HIGH}))
    else $error("forward reset state wrong");

  a_reset_rev_state: assert property (@(posedge clk)
    disable iff (sys_rst)
    (!brk_s && !tst_s && rst_s && !rot_s)
      |=> (phase_state == phase_set_t'{PH_HIGH, PH_LOW, PH_FLOAT}))
    else $error("reverse reset state wrong");

  a_step_advance: assert property (@(posedge clk) disable iff (sys_rst)
    (!brk_s && !tst_s && !rst_s && commutate)
      |=> (step == next_step($past(step))))
    else $error("step did not advance once");

  a_step_hold: assert property (@(posedge clk) disable iff (sys_rst)
    ((brk_s || tst_s || !commutate) && !rst_s) |=> $stable(step))
    else $error("step moved without event");

  a_fwd_sequence: assert property (@(posedge clk) disable iff (sys_rst)
    (!brk_s && !tst_s && !rst_s && rot_s)
      |=> (phase_state == fwd_pattern($past(step))))
    else $error("forward pattern wrong");

  a_rev_sequence: assert property (@(posedge clk) disable iff (sys_rst)
    (!brk_s && !tst_s && !rst_s && !rot_s)
      |=> (phase_state == rev_pattern($past(step))))
    else $error("reverse pattern wrong");

  a_hot_xtor_off: assert property (@(posedge clk) disable iff (sys_rst)
    (ot_s != '0) |=> ((xtor_on & $past(ot_s)) == '0))
    else $error("hot transistor left on");

  a_brake_priority: assert property (@(posedge clk) disable iff (sys_rst)
    (brk_s && tst_s) |=> (phase_state.a == PH_LOW))
    else $error("test overrode brake");

  a_reset_zero_step: assert property (@(posedge clk)
    disable iff (sys_rst)
    (!brk_s && !tst_s && rst_s) |=> (step == STEP_0))
    else $error("reset did not return step to start");

  // Test outranks reset, so the step must survive a reset under test
  a_test_over_reset: assert property (@(posedge clk)
    disable iff (sys_rst)
    (!brk_s && tst_s && rst_s) |=> $stable(step))
    else $error("reset acted while test was active");

  a_hot_high_off: assert property (@(posedge clk)
    disable iff (sys_rst)
    ot_s.c[0] |=> !(phase_c_oe && phase_c_drive))
    else $error("hot upper transistor still drives");

  a_hot_low_off: assert property (@(posedge clk)
    disable iff (sys_rst)
    ot_s.b[1] |=> !(phase_b_oe && !phase_b_drive))
    else $error("hot lower transistor still drives");

endmodule

// File: testbench/motor_windings.sv
module motor_windings (
  input  wire logic                   phase_a_drive,
  input  wire logic                   phase_b_drive,
  input  wire logic                   phase_c_drive,
  input  wire logic                   phase_a_oe,
  input  wire logic                   phase_b_oe,
  input  wire logic                   phase_c_oe,
  output commutation_pkg::phase_set_t sensed
);
  timeunit 1ns;
  timeprecision 1ps;
  import commutation_pkg::*;

  // An undriven winding is reported as floating, never as a stale level
  always_comb begin
    sensed.a = phase_a_oe ? (phase_a_drive ? PH_HIGH : PH_LOW) : PH_FLOAT;
    sensed.b = phase_b_oe ? (phase_b_drive ? PH_HIGH : PH_LOW) : PH_FLOAT;
    sensed.c = phase_c_oe ? (phase_c_drive ? PH_HIGH : PH_LOW) : PH_FLOAT;
  end
endmodule

// File: testbench/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import commutation_pkg::*;

  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       rotation_sel = 1'b1;
  logic       seq_reset = 1'b1;
  logic       brake = 1'b0;
  logic       test_disable = 1'b0;
  logic       commutate = 1'b0;
  xtor_set_t  overtemp = '0;
  phase_set_t phase_state;
  phase_set_t sensed;
  xtor_set_t  xtor_on;
  step_t      step;
  logic       a_drv, b_drv, c_drv, a_oe, b_oe, c_oe;
  int         failures = 0;
  int         comparisons = 0;
  // Patterns as packed a/b/c codes; index 0 is the reset state
  logic [5:0] fwd [6] = '{6'h06, 6'h24, 6'h21, 6'h09, 6'h18, 6'h12};
  logic [5:0] rev [6] = '{6'h24, 6'h06, 6'h12, 6'h18, 6'h09, 6'h21};

  always #25 clk = ~clk;

  three_phase_commutation_sequencer i_three_phase_commutation_sequencer (
    .clk(clk), .sys_rst(sys_rst), .rotation_sel(rotation_sel),
    .seq_reset(seq_reset), .brake(brake), .test_disable(test_disable),
    .commutate(commutate), .overtemp(overtemp), .phase_state(phase_state),
    .xtor_on(xtor_on), .phase_a_drive(a_drv), .phase_b_drive(b_drv),
    .phase_c_drive(c_drv), .phase_a_oe(a_oe), .phase_b_oe(b_oe),
    .phase_c_oe(c_oe), .step(step));

  motor_windings i_motor_windings (
    .phase_a_drive(a_drv), .phase_b_drive(b_drv), .phase_c_drive(c_drv),
    .phase_a_oe(a_oe), .phase_b_oe(b_oe), .phase_c_oe(c_oe),
    .sensed(sensed));

  ////////////////////////////////////////////////////////////////////////////
  // Inputs move 2 ns after the edge so no race with the design's flops
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic chk(input logic [5:0] st, input logic [5:0] pin);
    comparisons++;
    if (phase_state !== st || sensed !== pin) begin
      failures++;
      $display("CHECK FAILED at %0t: state %h pins %h", $time,
               phase_state, sensed);
    end
  endtask

  task automatic chk_step(input step_t s);
    comparisons++;
    if (step !== s) begin
      failures++;
      $display("CHECK FAILED at %0t: step %h", $time, step);
    end
  endtask

  // Commutate is not synchronised; pattern lags the step by one cycle
  task automatic pulse(input int n);
    commutate = 1'b1;
    tick(n);
    commutate = 1'b0;
    tick(3);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_sequence(input logic rot);
    logic [5:0] p [6];
    step_t      order [6];
    order = '{STEP_0, STEP_1, STEP_2, STEP_3, STEP_4, STEP_5};
    if (rot) begin
      p = fwd;
    end else begin
      p = rev;
    end
    rotation_sel = rot;
    seq_reset = 1'b1;
    tick(4);
    chk(p[0], p[0]);
    chk_step(STEP_0);
    seq_reset = 1'b0;
    tick(4);
    chk(p[0], p[0]);
    for (int i = 1; i <= 6; i++) begin
      pulse(1);
      chk(p[i % 6], p[i % 6]);
      chk_step(order[i % 6]);
    end
    pulse(2);
    chk(p[2], p[2]);
    chk_step(STEP_2);
    $display("sequence test done, rotation %0b", rot);
  endtask

  task automatic test_priority;
    brake = 1'b1;
    test_disable = 1'b1;
    tick(4);
    chk(6'h15, 6'h15);
    pulse(1);
    test_disable = 1'b0;
    tick(4);
    chk(6'h15, 6'h15);
    brake = 1'b0;
    test_disable = 1'b1;
    seq_reset = 1'b1;
    tick(4);
    chk(6'h00, 6'h00);
    seq_reset = 1'b0;
    tick(4);
    test_disable = 1'b0;
    tick(4);
    chk(rev[2], rev[2]);
    chk_step(STEP_2);
    $display("priority test done");
  endtask

  task automatic test_thermal;
    rotation_sel = 1'b1;
    seq_reset = 1'b1;
    overtemp.c = 2'h1;
    tick(4);
    chk(6'h06, 6'h04);
    comparisons++;
    if (xtor_on !== 6'h08) begin
      failures++;
      $display("CHECK FAILED at %0t: transistors %b", $time, xtor_on);
    end
    // Lower transistor of phase b hot: that leg must float as well
    overtemp = '{a: 2'h0, b: 2'h2, c: 2'h0};
    tick(4);
    chk(6'h06, 6'h02);
    overtemp = '0;
    tick(4);
    chk(6'h06, 6'h06);
    $display("thermal test done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    tick(5);
    sys_rst = 1'b0;
    test_sequence(1'b1);
    test_sequence(1'b0);
    test_priority();
    test_thermal();
    final_report();
  end
endmodule
